// >>> core/sar_seq_defs.vh
`ifndef SAR_SEQ_DEFS_VH
`define SAR_SEQ_DEFS_VH

// ==========================================================================
// Clocking and conversion timing
`define SEQ_SYS_CLK_MHZ     200
`define SEQ_CONV_MAX_MHZ    18
// Divider rounds up so the conversion clock never exceeds its maximum.
`define SEQ_CONV_DIV        ((`SEQ_SYS_CLK_MHZ + `SEQ_CONV_MAX_MHZ - 1) / `SEQ_CONV_MAX_MHZ)
`define SEQ_CONV_CLKS       18
`define SEQ_RES_BITS        12
`define SEQ_SAMPLE_MIN      (`SEQ_CONV_CLKS - `SEQ_RES_BITS)

// ==========================================================================
// Channels and field layout
`define SEQ_NUM_CH          8
`define SEQ_CH_W            3
`define SEQ_SAMP_W          8

// ==========================================================================
// Reset values
`define SEQ_RST_CODE        12'h000
`define SEQ_RST_CH          3'h0
`define SEQ_RST_SAMP        8'h00

`endif

// >>> core/sar_result_fifo.v
module sar_result_fifo #(
	parameter WIDTH = 15,
	parameter DEPTH = 2
) (
	// Clock and reset
	input  wire             clk_in,
	input  wire             rst_in,
	// Fill side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// Drain side
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	// The front word drives the outputs and a spare word catches one more during a stall.
	// This structure holds at most two entries, whatever DEPTH says.
	reg [WIDTH-1:0] front_q;
	reg [WIDTH-1:0] spare_q;
	reg             front_valid_q;
	reg             spare_valid_q;

	wire push = in_valid_in & in_ready_out;
	wire pop  = out_valid_out & out_ready_in;

	// Valid, ready and data all come from flip-flops, so no path runs straight through.
	assign in_ready_out  = ~spare_valid_q;
	assign out_valid_out = front_valid_q;
	assign out_data_out  = front_q;

	// ==========================================================================
	// Storage
	always @(posedge clk_in) begin
		if (rst_in) begin
			front_q       <= {WIDTH{1'b0}};
			spare_q       <= {WIDTH{1'b0}};
			front_valid_q <= 1'b0;
			spare_valid_q <= 1'b0;
		end else if (pop || !front_valid_q) begin
			if (spare_valid_q) begin
				front_q       <= spare_q;
				front_valid_q <= 1'b1;
				spare_valid_q <= 1'b0;
			end else begin
				front_q       <= in_data_in;
				front_valid_q <= push;
			end
		end else if (push) begin
			spare_q       <= in_data_in;
			spare_valid_q <= 1'b1;
		end
	end
endmodule // sar_result_fifo

// >>> core/sar_adc_channel_sequencer.v
`include "sar_seq_defs.vh"

module sar_adc_channel_sequencer #(
	parameter RES_W    = `SEQ_RES_BITS,
	parameter NUM_CH   = `SEQ_NUM_CH,
	parameter CONV_DIV = `SEQ_CONV_DIV
) (
	// Clock and reset
	input  wire                         clk_in,
	input  wire                         rst_in,
	// Control
	input  wire                         start_in,
	input  wire                         stop_in,
	input  wire                         continuous_in,
	input  wire                         deep_sleep_in,
	input  wire                         fw_select_in,
	input  wire [`SEQ_CH_W-1:0]         fw_ch_in,
	input  wire [NUM_CH-1:0]            ch_enable_in,
	input  wire [NUM_CH*`SEQ_SAMP_W-1:0] samp_time_in,
	input  wire [RES_W-1:0]             limit_lo_in,
	input  wire [RES_W-1:0]             limit_hi_in,
	// Analog front end
	input  wire                         cmp_in,
	output reg  [`SEQ_CH_W-1:0]         mux_sel_out,
	output reg                          sample_out,
	output reg  [RES_W-1:0]             dac_out,
	// Status
	output reg                          busy_out,
	output reg                          scan_done_out,
	output reg                          range_irq_out,
	output reg  [`SEQ_CH_W-1:0]         range_ch_out,
	// Per-channel result read
	input  wire [`SEQ_CH_W-1:0]         rd_ch_in,
	output reg  [RES_W-1:0]             rd_data_out,
	// Result stream
	output wire                         res_valid_out,
	input  wire                         res_ready_in,
	output wire [RES_W-1:0]             res_data_out,
	output wire [`SEQ_CH_W-1:0]         res_ch_out
);
	// ==========================================================================
	// States and constants
	localparam ST_IDLE    = 4'b0001;
	localparam ST_SAMPLE  = 4'b0010;
	localparam ST_CONVERT = 4'b0100;
	localparam ST_STORE   = 4'b1000;

	localparam integer DIV_W        = $clog2(CONV_DIV + 1);
	localparam integer SAMPLE_MIN_I = `SEQ_SAMPLE_MIN;
	localparam integer DIV_LAST_I   = CONV_DIV - 1;
	localparam integer CH_LAST_I    = NUM_CH - 1;
	localparam [`SEQ_SAMP_W-1:0] SAMPLE_MIN = SAMPLE_MIN_I[`SEQ_SAMP_W-1:0];
	localparam [DIV_W-1:0]       DIV_LAST   = DIV_LAST_I[DIV_W-1:0];
	localparam [`SEQ_CH_W-1:0]   CH_LAST    = CH_LAST_I[`SEQ_CH_W-1:0];

	reg [3:0]             state_q;
	reg [DIV_W-1:0]       div_q;
	reg [`SEQ_SAMP_W-1:0] samp_cnt_q;
	reg [RES_W-1:0]       bit_q;
	reg [RES_W-1:0]       code_q;
	reg [`SEQ_CH_W-1:0]   ch_q;
	reg [NUM_CH-1:0]      mask_q;
	reg                   fw_mode_q;
	reg [RES_W-1:0]       result_q [0:NUM_CH-1];
	integer               i;

	wire fifo_ready;
	wire tick = (div_q == DIV_LAST);

	// ==========================================================================
	// Helpers
	function [`SEQ_CH_W:0] next_enabled;
		input [NUM_CH-1:0]    mask;
		input [`SEQ_CH_W-1:0] from;
		input                 inclusive;
		integer k;
		reg                   found;
		reg [`SEQ_CH_W-1:0]   idx;
		begin
			found        = 1'b0;
			next_enabled = {1'b0, from};
			for (k = NUM_CH - 1; k >= 0; k = k - 1) begin
				idx = k[`SEQ_CH_W-1:0];
				if (mask[k] && (inclusive ? (idx >= from) : (idx > from))) begin
					found        = 1'b1;
					next_enabled = {1'b1, idx};
				end
			end
			if (!found) begin
				next_enabled = {1'b0, from};
			end
		end
	endfunction

	// Sample length never drops below the floor that keeps a conversion at its clock budget.
	function [`SEQ_SAMP_W-1:0] samp_len;
		input [`SEQ_CH_W-1:0] ch;
		reg [`SEQ_SAMP_W-1:0] t;
		begin
			t        = samp_time_in[ch*`SEQ_SAMP_W +: `SEQ_SAMP_W];
			samp_len = (t < SAMPLE_MIN) ? SAMPLE_MIN : t;
		end
	endfunction

	wire [`SEQ_CH_W:0] first_hit = next_enabled(ch_enable_in, {`SEQ_CH_W{1'b0}}, 1'b1);
	wire [`SEQ_CH_W:0] after_hit = next_enabled(mask_q, ch_q, 1'b0);
	wire [`SEQ_CH_W:0] wrap_hit  = next_enabled(mask_q, `SEQ_RST_CH, 1'b1);
	wire [RES_W-1:0]   final_code = cmp_in ? code_q : (code_q & ~bit_q);
	wire               store_go = (state_q == ST_STORE) & fifo_ready;

	// ==========================================================================
	// Result buffer between the converter and a receiver that may stall
	sar_result_fifo #(
		.WIDTH (RES_W + `SEQ_CH_W),
		.DEPTH (2)
	) u_result_fifo (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (store_go),
		.in_ready_out  (fifo_ready),
		.in_data_in    ({ch_q, code_q}),
		.out_valid_out (res_valid_out),
		.out_ready_in  (res_ready_in),
		.out_data_out  ({res_ch_out, res_data_out})
	);

	// ==========================================================================
	// Conversion clock divider
	always @(posedge clk_in) begin
		if (rst_in || deep_sleep_in) begin
			div_q <= {DIV_W{1'b0}};
		end else begin
			div_q <= tick ? {DIV_W{1'b0}} : div_q + 1'b1;
		end
	end

	// ==========================================================================
	// Sequencer and successive approximation
	always @(posedge clk_in) begin
		if (rst_in) begin
			state_q       <= ST_IDLE;
			samp_cnt_q    <= `SEQ_RST_SAMP;
			bit_q         <= `SEQ_RST_CODE;
			code_q        <= `SEQ_RST_CODE;
			ch_q          <= `SEQ_RST_CH;
			mask_q        <= {NUM_CH{1'b0}};
			fw_mode_q     <= 1'b0;
			mux_sel_out   <= `SEQ_RST_CH;
			sample_out    <= 1'b0;
			dac_out       <= `SEQ_RST_CODE;
			busy_out      <= 1'b0;
			scan_done_out <= 1'b0;
			range_irq_out <= 1'b0;
			range_ch_out  <= `SEQ_RST_CH;
			rd_data_out   <= `SEQ_RST_CODE;
			for (i = 0; i < NUM_CH; i = i + 1) begin
				result_q[i] <= `SEQ_RST_CODE;
			end
		end else begin
			scan_done_out <= 1'b0;
			range_irq_out <= 1'b0;
			rd_data_out   <= result_q[rd_ch_in];
			if (deep_sleep_in || stop_in) begin
				// The high-speed clock is gone in deep sleep, so any conversion is abandoned.
				state_q    <= ST_IDLE;
				sample_out <= 1'b0;
				busy_out   <= 1'b0;
			end else begin
				case (state_q)
					ST_IDLE: begin
						if (start_in && (fw_select_in || first_hit[`SEQ_CH_W])) begin
							fw_mode_q   <= fw_select_in;
							mask_q      <= ch_enable_in;
							ch_q        <= fw_select_in ? fw_ch_in : first_hit[`SEQ_CH_W-1:0];
							mux_sel_out <= fw_select_in ? fw_ch_in : first_hit[`SEQ_CH_W-1:0];
							samp_cnt_q  <= samp_len(fw_select_in ? fw_ch_in : first_hit[`SEQ_CH_W-1:0]);
							sample_out  <= 1'b1;
							busy_out    <= 1'b1;
							state_q     <= ST_SAMPLE;
						end
					end
					ST_SAMPLE: begin
						if (tick) begin
							if (samp_cnt_q <= 8'h01) begin
								sample_out <= 1'b0;
								bit_q      <= {1'b1, {(RES_W-1){1'b0}}};
								code_q     <= {1'b1, {(RES_W-1){1'b0}}};
								dac_out    <= {1'b1, {(RES_W-1){1'b0}}};
								state_q    <= ST_CONVERT;
							end else begin
								samp_cnt_q <= samp_cnt_q - 1'b1;
							end
						end
					end
					ST_CONVERT: begin
						if (tick) begin
							// One trial bit per conversion clock, most significant first.
							code_q  <= final_code | (bit_q >> 1);
							dac_out <= final_code | (bit_q >> 1);
							bit_q   <= bit_q >> 1;
							if (bit_q[0]) begin
								code_q  <= final_code;
								dac_out <= final_code;
								state_q <= ST_STORE;
							end
						end
					end
					ST_STORE: begin
						// When the buffer has room, the store takes one system clock inside a conversion clock period,
						// so the next sample still begins on the very next conversion tick.
						if (fifo_ready) begin
							result_q[ch_q] <= code_q;
							if ((code_q < limit_lo_in) || (code_q > limit_hi_in)) begin
								range_irq_out <= 1'b1;
								range_ch_out  <= ch_q;
							end
							if (fw_mode_q) begin
								state_q  <= ST_IDLE;
								busy_out <= 1'b0;
							end else if (after_hit[`SEQ_CH_W] && (ch_q != CH_LAST)) begin
								ch_q        <= after_hit[`SEQ_CH_W-1:0];
								mux_sel_out <= after_hit[`SEQ_CH_W-1:0];
								samp_cnt_q  <= samp_len(after_hit[`SEQ_CH_W-1:0]);
								sample_out  <= 1'b1;
								state_q     <= ST_SAMPLE;
							end else begin
								scan_done_out <= 1'b1;
								if (continuous_in) begin
									ch_q        <= wrap_hit[`SEQ_CH_W-1:0];
									mux_sel_out <= wrap_hit[`SEQ_CH_W-1:0];
									samp_cnt_q  <= samp_len(wrap_hit[`SEQ_CH_W-1:0]);
									sample_out  <= 1'b1;
									state_q     <= ST_SAMPLE;
								end else begin
									state_q  <= ST_IDLE;
									busy_out <= 1'b0;
								end
							end
						end
					end
					default: begin
						state_q    <= ST_IDLE;
						sample_out <= 1'b0;
						busy_out   <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule // sar_adc_channel_sequencer

// >>> testbench/analog_source.sv
module analog_source (
	// Converter side
	input  wire  [2:0]  mux_sel_in,
	input  wire  [11:0] dac_in,
	input  wire  [95:0] level_in,
	output logic        cmp_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Only the routed channel reaches the comparator.
	always_comb cmp_out = level_in[mux_sel_in*12 +: 12] >= dac_in;
endmodule // analog_source

// >>> testbench/sar_adc_channel_sequencer_assertions.sv
module sar_checker #(parameter NUM_CH = 8) (
	input wire              clk_in,
	input wire              rst_in,
	input wire              start_in,
	input wire              stop_in,
	input wire              deep_sleep_in,
	input wire              fw_select_in,
	input wire [2:0]        fw_ch_in,
	input wire [NUM_CH-1:0] ch_enable_in,
	input wire              res_ready_in,
	input wire [2:0]        mux_sel_out,
	input wire              sample_out,
	input wire [11:0]       dac_out,
	input wire              busy_out,
	input wire              scan_done_out,
	input wire              range_irq_out,
	input wire              res_valid_out,
	input wire [11:0]       res_data_out,
	input wire [2:0]        res_ch_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [15:0] hi_q;
	logic [15:0] lo_q;
	wire take = !busy_out && start_in && !stop_in && !deep_sleep_in && (fw_select_in || |ch_enable_in);
	// Counters hold window lengths, which are too long for a repetition.
	always @(posedge clk_in) begin
		hi_q <= sample_out ? hi_q + 16'h1 : 16'h0;
		lo_q <= (busy_out && !sample_out) ? lo_q + 16'h1 : 16'h0;
	end
	AST_SAMPLE_MIN: assert property (
		$fell(sample_out) && busy_out |-> hi_q >= 16'h3c) else $error("sample window short");
	AST_CONV_MIN: assert property (
		$rose(sample_out) && $past(busy_out) |-> lo_q >= 16'h8f) else $error("conversion short");
	AST_MSB_FIRST: assert property (
		$fell(sample_out) && busy_out |-> dac_out == 12'h800) else $error("first trial wrong");
	AST_SLEEP_IDLE: assert property (
		deep_sleep_in |=> !busy_out && !sample_out) else $error("active in sleep");
	AST_START_TAKE: assert property (
		take |=> busy_out && sample_out) else $error("start not taken");
	AST_FW_CH: assert property (
		take && fw_select_in |=> mux_sel_out == $past(fw_ch_in)) else $error("wrong fw channel");
	AST_REFUSE_EMPTY: assert property (
		!busy_out && !fw_select_in && ch_enable_in == 0 |=> !busy_out) else $error("empty start");
	AST_MUX_HOLD: assert property (
		busy_out && !sample_out |-> $stable(mux_sel_out)) else $error("channel moved");
	AST_IRQ_PULSE: assert property (
		range_irq_out |=> !range_irq_out) else $error("range flag not a pulse");
	AST_DONE_PULSE: assert property (
		scan_done_out |=> !scan_done_out) else $error("scan flag not a pulse");
	AST_RES_HOLD: assert property (
		res_valid_out && !res_ready_in |=> res_valid_out && $stable({res_ch_out, res_data_out}))
		else $error("stalled word lost");
endmodule // sar_checker

// >>> testbench/sar_adc_channel_sequencer_tb.sv
module sar_adc_channel_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 0, rst_in = 1, start_in = 0, stop_in = 0, deep_sleep_in = 0;
	logic        fw_select_in = 0, res_ready_in = 0, cmp_in, stall = 0, continuous_in = 0;
	logic        samp_q = 0, gap_on = 0;
	int          cyc = 0, fall_at = 0;
	logic        sample_out, busy_out, scan_done_out, range_irq_out, res_valid_out;
	logic [2:0]  fw_ch_in = 0, rd_ch_in = 0, mux_sel_out, range_ch_out, res_ch_out;
	logic [7:0]  ch_enable_in = 0;
	logic [63:0] samp_time_in = 0;
	logic [11:0] limit_lo_in = 0, limit_hi_in = 12'hfff, dac_out, rd_data_out, res_data_out;
	logic [95:0] level = 0;
	logic [14:0] exp_q[$];
	logic [11:0] exp_rd[8] = '{default: 12'h000};
	int          fails = 0, n_tests = 0, n_irq = 0, exp_irq = 0, n_done = 0;
	sar_adc_channel_sequencer i_sar_adc_channel_sequencer (.clk_in(clk_in), .rst_in(rst_in),
		.start_in(start_in), .stop_in(stop_in), .continuous_in(continuous_in),
		.deep_sleep_in(deep_sleep_in), .fw_select_in(fw_select_in), .fw_ch_in(fw_ch_in),
		.ch_enable_in(ch_enable_in), .samp_time_in(samp_time_in), .limit_lo_in(limit_lo_in),
		.limit_hi_in(limit_hi_in), .cmp_in(cmp_in), .mux_sel_out(mux_sel_out),
		.sample_out(sample_out), .dac_out(dac_out), .busy_out(busy_out),
		.scan_done_out(scan_done_out), .range_irq_out(range_irq_out),
		.range_ch_out(range_ch_out), .rd_ch_in(rd_ch_in), .rd_data_out(rd_data_out),
		.res_valid_out(res_valid_out), .res_ready_in(res_ready_in),
		.res_data_out(res_data_out), .res_ch_out(res_ch_out));
	analog_source i_analog_source (.mux_sel_in(mux_sel_out), .dac_in(dac_out),
		.level_in(level), .cmp_out(cmp_in));
	initial forever #2.5 clk_in = ~clk_in;
	function logic [11:0] lv(int c);
		return level[c*12 +: 12];
	endfunction
	function logic oor(int c);
		return lv(c) < limit_lo_in || lv(c) > limit_hi_in;
	endfunction
	function int sl(int c);
		return samp_time_in[c*8 +: 8] < 6 ? 6 : samp_time_in[c*8 +: 8];
	endfunction
	task check(string what, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================================================
	// Monitor: the receiver stalls at random, or fully while stall is set.
	always @(posedge clk_in) begin
		res_ready_in <= stall ? 1'b0 : 1'($urandom_range(1));
		if (!rst_in && res_valid_out && res_ready_in)
			check("word", {res_ch_out, res_data_out}, exp_q.size() ? exp_q.pop_front() : 15'h7fff);
		if (!rst_in && range_irq_out) begin
			n_irq++;
			check("range", oor(range_ch_out), 1);
		end
		if (!rst_in && scan_done_out)
			n_done++;
		// Sample end to sample end is one conversion plus the next window, with no idle clock.
		if (rst_in || stall || !busy_out)
			gap_on = 0;
		else if (samp_q && !sample_out) begin
			if (gap_on)
				check("gap", 16'(cyc - fall_at), 16'(12 * (12 + sl(mux_sel_out))));
			gap_on = 1;
			fall_at = cyc;
		end
		samp_q = sample_out;
		cyc++;
	end
	task run(logic fw, logic [2:0] ch, logic [7:0] mask, logic cont);
		int k, d;
		d = n_done;
		@(posedge clk_in);
		fw_select_in <= fw;
		fw_ch_in <= ch;
		ch_enable_in <= mask;
		continuous_in <= cont;
		start_in <= 1;
		for (int r = 0; r <= int'(cont); r++)
			for (int c = 0; c < 8; c++)
				if (fw ? c == ch : mask[c]) begin
					exp_q.push_back({3'(c), lv(c)});
					exp_rd[c] = lv(c);
					exp_irq += oor(c);
				end
		@(posedge clk_in);
		start_in <= 0;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
			if (k == 2000)
				stall = 0;
			if (n_done != d)
				continuous_in <= 0;
		end while ((busy_out !== 1'b0 || exp_q.size() > 0) && k < 20000);
		check("finished", 16'(k < 20000), 1);
		check("scan done", 16'(n_done - d), 16'(fw ? 0 : cont ? 2 : 1));
		for (int c = 0; c < 8; c++) begin
			rd_ch_in <= 3'(c);
			repeat (2) @(posedge clk_in);
			check("result", rd_data_out, exp_rd[c]);
		end
		$display("run done fw %0d mask %h", fw, mask);
	endtask
	initial begin
		void'($urandom(32'hd3de3132));
		repeat (3) @(posedge clk_in);
		rst_in <= 0;
		for (int t = 0; t < 3; t++) begin
			level = {$urandom, $urandom, $urandom};
			samp_time_in <= {$urandom, $urandom} & {8{8'h0f}};
			limit_lo_in <= 12'($urandom_range(0, 2047));
			limit_hi_in <= 12'($urandom_range(2048, 4095));
			stall = (t == 0);
			run(0, 0, t == 0 ? 8'hff : t == 1 ? 8'h81 : 8'($urandom_range(1, 255)), t == 1);
		end
		// Limits equal to the value must stay quiet; one step off must flag.
		level[36 +: 12] = 12'h5a5;
		for (int b = 0; b < 3; b++) begin
			limit_lo_in <= b == 1 ? 12'h5a6 : b == 2 ? 12'h000 : 12'h5a5;
			limit_hi_in <= b == 2 ? 12'h5a4 : 12'h5a5;
			run(1, 3, 8'h00, 0);
		end
		for (int s = 0; s < 2; s++) begin
			@(posedge clk_in);
			ch_enable_in <= 8'h00;
			fw_select_in <= 0;
			start_in <= 1;
			repeat (3) @(posedge clk_in);
			check("refused", busy_out, 0);
			ch_enable_in <= 8'hff;
			repeat (150) @(posedge clk_in);
			{deep_sleep_in, stop_in} <= s ? 2'b10 : 2'b01;
			start_in <= 0;
			repeat (2) @(posedge clk_in);
			check("halt", {busy_out, sample_out}, 0);
			{deep_sleep_in, stop_in} <= 2'b00;
			$display("abort done %0d", s);
		end
		check("range count", 16'(n_irq), 16'(exp_irq));
		summarize;
	end
	initial begin
		#400000;
		fails++;
		summarize;
	end
endmodule // sar_adc_channel_sequencer_tb
bind sar_adc_channel_sequencer sar_checker #(.NUM_CH(NUM_CH)) i_sar_checker (.clk_in(clk_in),
	.rst_in(rst_in), .start_in(start_in), .stop_in(stop_in), .deep_sleep_in(deep_sleep_in),
	.fw_select_in(fw_select_in), .fw_ch_in(fw_ch_in), .ch_enable_in(ch_enable_in),
	.res_ready_in(res_ready_in), .mux_sel_out(mux_sel_out), .sample_out(sample_out),
	.dac_out(dac_out), .busy_out(busy_out), .scan_done_out(scan_done_out),
	.range_irq_out(range_irq_out), .res_valid_out(res_valid_out),
	.res_data_out(res_data_out), .res_ch_out(res_ch_out));
